// >>> src/poa_output.v
// activation logic for one programmable alarm-panel output
// assumes trigger states arrive synchronous to sys_clk, one bit per condition
`timescale 1ns/100ps
`include "poa_map.vh"
module poa_output #(
  parameter RESTART_MS = `POA_RESTART_MS,
  parameter RPULSE_MS = `POA_RPULSE_MS
) (
  // clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // system state
  input wire [`POA_TRIG_NUM:1] trig_in,
  input wire [63:1] time_chan_act,
  input wire rst_pulse_stb,
  input wire [15:0] rst_pulse_zone_addr,
  // output driver
  output reg out_drive,
  output reg out_supervise,
  output reg req_q
);
  localparam CYC_PER_MS = `POA_CLK_KHZ; // system cycles in one millisecond
  // program memory: term ops and operands, postfix order
  reg [2:0] prog_op [0:`POA_TERMS*2-1];
  reg [5:0] prog_arg [0:`POA_TERMS*2-1];
  reg [31:0] ctrl_q, delay_q, plen_q, poff_q, deact_q;
  reg [6:0] prog_idx_q;
  reg [5:0] chan_q;
  reg [13:0] div_q;
  reg ms_tick_q;
  // evaluation state
  reg [6:0] pc_q;
  reg [31:0] stk_q;
  reg [5:0] sp_q;
  reg rp_act_q;
  reg [15:0] rp_ms_q;
  reg [15:0] rs_ms_q;
  reg pulse_used_q, phase_q, held_q;
  reg [31:0] ph_load;
  reg ph_ld;
  wire ph_done;
  wire [2:0] typ_raw = ctrl_q[`POA_F_TYPE_LO+2:`POA_F_TYPE_LO];
  wire [2:0] cls = ctrl_q[`POA_F_CLASS_LO+2:`POA_F_CLASS_LO];
  wire nhigh = ctrl_q[`POA_F_NHIGH];
  wire panel = (cls == `POA_C_PANEL_VOLT) || (cls == `POA_C_PANEL_RELAY);
  wire dualv = (cls == `POA_C_LOOP_DUALV);
  wire is_inter = (typ_raw == `POA_T_INTER) || (typ_raw == `POA_T_INTER_DA);
  wire is_pulse = (typ_raw == `POA_T_PULSE) || (typ_raw == `POA_T_PULSE_DA);
  reg [2:0] typ;
  // restrict types by output class
  always @* begin
    typ = typ_raw;
    if (typ_raw > `POA_T_STEADY_DD)
      typ = `POA_T_STEADY;
    else if (!panel && !(dualv && is_inter) && (is_inter || is_pulse))
      typ = (typ_raw >= `POA_T_STEADY_DA) ? `POA_T_STEADY_DA : `POA_T_STEADY;
  end
  wire delayed = (typ == `POA_T_STEADY_DA) || (typ == `POA_T_INTER_DA) ||
                 (typ == `POA_T_PULSE_DA);
  wire t_inter = (typ == `POA_T_INTER) || (typ == `POA_T_INTER_DA);
  wire t_pulse = (typ == `POA_T_PULSE) || (typ == `POA_T_PULSE_DA);
  // on/off cadence: dual voltage unit fixed, else programmed or default
  wire [31:0] on_ms = (dualv || plen_q == 32'h0) ? `POA_CADENCE_MS : plen_q;
  wire [31:0] off_ms = (dualv || poff_q == 32'h0) ? `POA_CADENCE_MS : poff_q;
  // one trigger lookup shared by the evaluator
  function trig_val;
    input [5:0] n;
    input [`POA_TRIG_NUM:1] t;
    input rp;
    input tc;
    input ok_rp;
    begin
      if (n == `POA_TRIG_ENCAP)
        trig_val = 1'b0;
      else if (n == `POA_TRIG_RESET)
        trig_val = rp & ok_rp;
      else if (n == `POA_TRIG_TIMECH)
        trig_val = tc;
      else if (n >= 6'h01 && n <= 6'h2d)
        trig_val = t[n];
      else
        trig_val = 1'b0;
    end
  endfunction
  wire rp_ok = panel || cls == `POA_C_RELAY_BOARD || cls == `POA_C_LOOP_MULTI;
  wire tc_v = (chan_q != 6'h0) && time_chan_act[chan_q];
  // register writes and program loading
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `POA_R_CTRL;
      delay_q <= `POA_R_TIME;
      plen_q <= `POA_R_TIME;
      poff_q <= `POA_R_TIME;
      deact_q <= `POA_R_TIME;
      prog_idx_q <= 7'h0;
      chan_q <= 6'h0;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `POA_A_CTRL) begin
        ctrl_q <= reg_wdata;
        prog_idx_q <= 7'h0;
      end else if (reg_addr == `POA_A_DELAY)
        delay_q <= reg_wdata;
      else if (reg_addr == `POA_A_PLEN)
        plen_q <= reg_wdata;
      else if (reg_addr == `POA_A_POFF)
        poff_q <= reg_wdata;
      else if (reg_addr == `POA_A_DEACT)
        deact_q <= reg_wdata;
      else if (reg_addr == `POA_A_CHAN)
        chan_q <= reg_wdata[5:0];
      else if (reg_addr == `POA_A_PROG && prog_idx_q < 7'd80)
        prog_idx_q <= prog_idx_q + 7'h1;
    end
  end
  // program store, no reset needed for memory
  always @(posedge sys_clk) begin
    if (clk_en && reg_wr && reg_addr == `POA_A_PROG && prog_idx_q < 7'd80) begin
      prog_op[prog_idx_q] <= reg_wdata[10:8];
      prog_arg[prog_idx_q] <= reg_wdata[5:0];
    end
  end
  // register reads, data one cycle later
  always @(posedge sys_clk) begin
    if (rst)
      reg_rdata <= 32'h0;
    else if (clk_en) begin
      if (!reg_rd)
        reg_rdata <= 32'h0;
      else if (reg_addr == `POA_A_CTRL)
        reg_rdata <= ctrl_q;
      else if (reg_addr == `POA_A_DELAY)
        reg_rdata <= delay_q;
      else if (reg_addr == `POA_A_PLEN)
        reg_rdata <= plen_q;
      else if (reg_addr == `POA_A_POFF)
        reg_rdata <= poff_q;
      else if (reg_addr == `POA_A_DEACT)
        reg_rdata <= deact_q;
      else if (reg_addr == `POA_A_CHAN)
        reg_rdata <= {26'h0, chan_q};
      else if (reg_addr == `POA_A_STAT)
        reg_rdata <= {22'h0, typ, rs_ms_q != 16'h0, rp_act_q, held_q, req_q,
                      out_drive, out_supervise, prog_idx_q == 7'h0 ? 1'b0 : 1'b1};
      else
        reg_rdata <= 32'h0;
    end
  end
  // millisecond tick
  always @(posedge sys_clk) begin
    if (rst) begin
      div_q <= 14'h0;
      ms_tick_q <= 1'b0;
    end else if (clk_en) begin
      ms_tick_q <= (div_q == CYC_PER_MS[13:0] - 14'h1);
      div_q <= (div_q == CYC_PER_MS[13:0] - 14'h1) ? 14'h0 : div_q + 14'h1;
    end
  end
  // reset pulse condition held five seconds
  always @(posedge sys_clk) begin
    if (rst) begin
      rp_act_q <= 1'b0;
      rp_ms_q <= 16'h0;
    end else if (clk_en) begin
      if (rst_pulse_stb && rst_pulse_zone_addr == ctrl_q[`POA_F_RPZONE_LO+15:`POA_F_RPZONE_LO]) begin
        rp_ms_q <= RPULSE_MS[15:0];
        rp_act_q <= 1'b1;
      end else if (ms_tick_q) begin
        if (rp_ms_q <= 16'h1)
          rp_act_q <= 1'b0;
        if (rp_ms_q != 16'h0)
          rp_ms_q <= rp_ms_q - 16'h1;
      end
    end
  end
  // postfix evaluator: one op per cycle, stack bit 0 is top
  always @(posedge sys_clk) begin
    if (rst) begin
      pc_q <= 7'h0;
      sp_q <= 6'h0;
      stk_q <= 32'h0;
      req_q <= 1'b0;
    end else if (clk_en) begin
      if (pc_q >= prog_idx_q || prog_op[pc_q] == `POA_OP_END) begin
        req_q <= (sp_q != 6'h0) & stk_q[0];
        pc_q <= 7'h0;
        sp_q <= 6'h0;
        stk_q <= 32'h0;
      end else begin
        pc_q <= pc_q + 7'h1;
        case (prog_op[pc_q])
          `POA_OP_PUSH: begin
            stk_q <= {stk_q[30:0], trig_val(prog_arg[pc_q], trig_in, rp_act_q, tc_v, rp_ok)};
            sp_q <= sp_q + 6'h1;
          end
          `POA_OP_NOT: stk_q[0] <= ~stk_q[0];
          `POA_OP_AND: begin
            stk_q <= {1'b0, stk_q[31:2], stk_q[1] & stk_q[0]};
            sp_q <= sp_q - 6'h1;
          end
          `POA_OP_OR: begin
            stk_q <= {1'b0, stk_q[31:2], stk_q[1] | stk_q[0]};
            sp_q <= sp_q - 6'h1;
          end
          default: pc_q <= 7'h0;
        endcase
      end
    end
  end
  // shared phase timer
  poa_timer #(.W(32)) u_ph (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .ms_tick(ms_tick_q),
    .load(ph_ld),
    .load_val(ph_load),
    .done(ph_done)
  );
  localparam S_IDLE = 5'h01;
  localparam S_WAIT = 5'h02;
  localparam S_ON = 5'h04;
  localparam S_OFF = 5'h08;
  localparam S_HOLD = 5'h10;
  reg [4:0] st_q, st_d;
  // next state and timer loads
  always @* begin
    st_d = st_q;
    ph_ld = 1'b0;
    ph_load = 32'h0;
    case (st_q)
      S_IDLE: begin
        if (req_q && !(t_pulse && pulse_used_q)) begin
          ph_ld = 1'b1;
          if (delayed) begin
            st_d = S_WAIT;
            ph_load = delay_q;
          end else begin
            st_d = S_ON;
            ph_load = t_pulse ? plen_q : on_ms;
          end
        end
      end
      S_WAIT: begin
        if (!req_q)
          st_d = S_IDLE;
        else if (ph_done) begin
          st_d = S_ON;
          ph_ld = 1'b1;
          ph_load = t_pulse ? plen_q : on_ms;
        end
      end
      S_ON: begin
        if (!req_q && typ == `POA_T_STEADY_DD) begin
          st_d = S_HOLD;
          ph_ld = 1'b1;
          ph_load = deact_q;
        end else if (!req_q)
          st_d = S_IDLE;
        else if (t_pulse && ph_done)
          st_d = S_IDLE;
        else if (t_inter && ph_done) begin
          st_d = S_OFF;
          ph_ld = 1'b1;
          ph_load = off_ms;
        end
      end
      S_OFF: begin
        if (!req_q)
          st_d = S_IDLE;
        else if (ph_done) begin
          st_d = S_ON;
          ph_ld = 1'b1;
          ph_load = on_ms;
        end
      end
      S_HOLD: begin
        if (req_q)
          st_d = S_ON;
        else if (ph_done)
          st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end
  // shaper state, pulse latch and output pins
  always @(posedge sys_clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      pulse_used_q <= 1'b0;
      phase_q <= 1'b0;
      held_q <= 1'b0;
      rs_ms_q <= 16'hffff;
      out_drive <= 1'b0;
      out_supervise <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      if (!req_q)
        pulse_used_q <= 1'b0;
      else if (st_q == S_ON && t_pulse)
        pulse_used_q <= 1'b1;
      held_q <= (st_d == S_HOLD);
      phase_q <= (st_d == S_ON) || (st_d == S_HOLD);
      if (rs_ms_q == 16'hffff)
        rs_ms_q <= RESTART_MS[15:0];
      else if (ms_tick_q && rs_ms_q != 16'h0)
        rs_ms_q <= rs_ms_q - 16'h1;
      // normally high idles high, held low during restart window
      if (nhigh && rs_ms_q != 16'h0)
        out_drive <= 1'b0;
      else
        out_drive <= nhigh ^ phase_q;
      out_supervise <= ctrl_q[`POA_F_SUPV] & ~nhigh;
    end
  end
endmodule // poa_output

// >>> include/poa_map.vh
// constants for the programmable output activation block
// assumes a 10 MHz system clock; included by bare name
`ifndef POA_MAP_VH
`define POA_MAP_VH
// activation types
`define POA_T_STEADY 3'h0
`define POA_T_INTER 3'h1
`define POA_T_PULSE 3'h2
`define POA_T_STEADY_DA 3'h3
`define POA_T_INTER_DA 3'h4
`define POA_T_PULSE_DA 3'h5
`define POA_T_STEADY_DD 3'h6
// output classes
`define POA_C_PANEL_VOLT 3'h0
`define POA_C_PANEL_RELAY 3'h1
`define POA_C_RELAY_BOARD 3'h2
`define POA_C_LOOP_MULTI 3'h3
`define POA_C_LOOP_DUALV 3'h4
`define POA_C_SOUNDER 3'h5
// register offsets
`define POA_A_CTRL 4'h0
`define POA_A_DELAY 4'h1
`define POA_A_PLEN 4'h2
`define POA_A_POFF 4'h3
`define POA_A_DEACT 4'h4
`define POA_A_PROG 4'h8
`define POA_A_CHAN 4'h9
`define POA_A_STAT 4'hf
// ctrl field positions
`define POA_F_TYPE_LO 0
`define POA_F_CLASS_LO 4
`define POA_F_NHIGH 8
`define POA_F_SUPV 9
`define POA_F_RPZONE_LO 16
// reset values
`define POA_R_CTRL 32'h0000_0000
`define POA_R_TIME 32'h0000_0000
// timing, in ms, and ticks per ms at 10 MHz
`define POA_CLK_KHZ 10000
`define POA_CADENCE_MS 800
`define POA_RPULSE_MS 5000
`define POA_RESTART_MS 3000
// program: up to 40 terms, ops
`define POA_TERMS 40
`define POA_TRIG_NUM 45
`define POA_TRIG_ENCAP 40
`define POA_TRIG_RESET 27
`define POA_TRIG_TIMECH 28
`define POA_OP_END 3'h0
`define POA_OP_PUSH 3'h1
`define POA_OP_NOT 3'h2
`define POA_OP_AND 3'h3
`define POA_OP_OR 3'h4
`endif

// >>> src/poa_timer.v
// down counter in milliseconds for the activation shaper
// assumes a shared tick pulse of one millisecond
`timescale 1ns/100ps
module poa_timer #(
  parameter W = 32
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  // control
  input wire ms_tick,
  input wire load,
  input wire [W-1:0] load_val,
  // status
  output wire done
);
  reg [W-1:0] cnt_q;
  // load wins over counting
  always @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
    end else if (clk_en) begin
      if (load)
        cnt_q <= load_val;
      else if (ms_tick && cnt_q != {W{1'b0}})
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign done = (cnt_q == {W{1'b0}});
endmodule // poa_timer

// >>> verif/poa_output_assertions.sv
// port-level checks for one programmable output
// assumes one 10 MHz clock and sync high reset; bound to the design top
`timescale 1ns/100ps
`include "poa_map.vh"
module poa_output_assertions #(
  parameter RESTART_MS = `POA_RESTART_MS
) (
  // clock, reset, enable
  input wire sys_clk,
  input wire rst,
  input wire clk_en,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // output driver
  input wire out_drive,
  input wire out_supervise,
  input wire req_q
);
  localparam int RESTART_LOW = (RESTART_MS - 1) * `POA_CLK_KHZ;
  reg [31:0] ctrl_q;
  reg [31:0] delay_q;
  reg [31:0] up_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow of software writes, cycles since reset
  always @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= `POA_R_CTRL;
      delay_q <= `POA_R_TIME;
      up_q <= 32'h0;
    end else if (clk_en) begin
      up_q <= up_q + 32'h1;
      if (reg_wr && reg_addr == `POA_A_CTRL) ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == `POA_A_DELAY) delay_q <= reg_wdata;
    end
  end
  a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside answer cycle");
  a_unmapped_zero: assert property ($past(clk_en && reg_rd) &&
    ($past(reg_addr) inside {[4'h5:4'h7], [4'ha:4'he]}) |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_readback: assert property (
    $past(clk_en && reg_rd && reg_addr == `POA_A_CTRL) |->
    (reg_rdata & 32'hffff0377) == (ctrl_q & 32'hffff0377))
    else $error("control readback differs");
  a_delay_readback: assert property (
    $past(clk_en && reg_rd && reg_addr == `POA_A_DELAY) |->
    reg_rdata[15:0] == delay_q[15:0])
    else $error("delay readback differs");
  a_freeze_hold: assert property (!clk_en |=> $stable(req_q) && $stable(out_drive))
    else $error("state moved while frozen");
  a_nhigh_nosupv: assert property (
    $past(ctrl_q[`POA_F_NHIGH]) && $past(ctrl_q[`POA_F_NHIGH], 2) |-> !out_supervise)
    else $error("normally high output supervised");
  a_restart_low: assert property (
    ctrl_q[`POA_F_NHIGH] && up_q < RESTART_LOW |-> !out_drive)
    else $error("normally high output driven during restart");
  a_reset_outs: assert property ($past(rst) |-> !out_drive && !req_q && !out_supervise)
    else $error("outputs not clear after reset");
endmodule // poa_output_assertions
bind poa_output poa_output_assertions #(.RESTART_MS(RESTART_MS)) u_poa_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .clk_en(clk_en),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .out_drive(out_drive),
  .out_supervise(out_supervise),
  .req_q(req_q)
);

// >>> verif/programmable_output_activation_bench.sv
// self-checking bench for one programmable output
// assumes poa_output with shortened restart and reset-pulse times
`timescale 1ns/100ps
`include "poa_map.vh"
module programmable_output_activation_bench;
  localparam integer RST_MS = 2;
  localparam integer RP_MS = 2;
  localparam [83:0] CASES = {12'h220, 12'h253, 12'h411, 12'h543, 12'h510, 12'h366, 12'h420};
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg clk_en = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [45:1] trig_in = 45'h0;
  reg [63:1] time_chan_act = 63'h0;
  reg rst_pulse_stb = 1'b0;
  reg [15:0] rst_pulse_zone_addr = 16'h0;
  wire [31:0] reg_rdata;
  wire out_drive;
  wire out_supervise;
  wire req_q;
  reg [31:0] d;
  reg [11:0] c;
  integer n_fail = 0;
  integer total_checks = 0;
  integer i;
  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;
  poa_output #(.RESTART_MS(RST_MS), .RPULSE_MS(RP_MS)) dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_en(clk_en),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .trig_in(trig_in),
    .time_chan_act(time_chan_act),
    .rst_pulse_stb(rst_pulse_stb),
    .rst_pulse_zone_addr(rst_pulse_zone_addr),
    .out_drive(out_drive),
    .out_supervise(out_supervise),
    .req_q(req_q)
  );
  // compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge sys_clk);
      #1;
    end
  endtask
  // one-cycle register write and read
  task wr(input [3:0] a, input [31:0] v);
    begin
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, output [31:0] v);
    begin
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
    end
  endtask
  // control word, then eight program entries, first in the top bits
  task ld(input [31:0] ctl, input [87:0] p);
    integer k;
    begin
      wr(`POA_A_CTRL, ctl);
      for (k = 7; k >= 0; k = k - 1) begin
        wr(`POA_A_PROG, {21'h0, p[k*11 +: 11]});
      end
      cyc(20);
    end
  endtask
  task pulse(input [15:0] z);
    begin
      @(posedge sys_clk);
      rst_pulse_stb <= 1'b1;
      rst_pulse_zone_addr <= z;
      @(posedge sys_clk);
      rst_pulse_stb <= 1'b0;
      cyc(20);
    end
  endtask
  function [10:0] ps(input integer n);
    ps = {3'h1, 2'h0, n[5:0]};
  endfunction
  function [31:0] cf(input [2:0] t, input [2:0] k, input nh, input sv, input [15:0] z);
    cf = {z, 6'h0, sv, nh, 1'b0, k, 1'b0, t};
  endfunction
  task final_report;
    begin
      if (n_fail == 0 && total_checks > 0) begin
        $display("ALL CHECKS OK");
      end else begin
        $display("CHECKS NOT OK");
      end
      $finish;
    end
  endtask
  // hang guard
  initial begin
    #(99000 * 100);
    n_fail = n_fail + 1;
    final_report;
  end
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`POA_A_CTRL, d);
    chk(d, `POA_R_CTRL);
    rd(`POA_A_DELAY, d);
    chk(d, `POA_R_TIME);
    rd(4'h6, d);
    chk(d, 32'h0);
    ld(cf(3'h0, 3'h0, 1'b1, 1'b1, 16'h0), {ps(40), 77'h0});
    chk(out_drive, 0);
    chk(out_supervise, 0);
    @(posedge sys_clk) trig_in <= {45{1'b1}};
    cyc(20);
    chk(req_q, 0);
    // a OR NOT b AND c over all inputs
    ld(cf(3'h0, 3'h0, 1'b0, 1'b0, 16'h0),
      {ps(1), ps(2), 11'h200, ps(3), 11'h300, 11'h400, 22'h0});
    for (i = 0; i < 8; i = i + 1) begin
      @(posedge sys_clk) trig_in <= {42'h0, i[2:0]};
      cyc(20);
      chk(req_q, i[0] | (~i[1] & i[2]));
      chk(out_drive, i[0] | (~i[1] & i[2]));
    end
    @(posedge sys_clk) clk_en <= 1'b0;
    trig_in <= 45'h0;
    cyc(10);
    chk(req_q, 1);
    @(posedge sys_clk) clk_en <= 1'b1;
    cyc(20);
    chk(req_q, 0);
    // effective type per code and per output class
    for (i = 0; i < 7; i = i + 1) begin
      wr(`POA_A_CTRL, cf(i[2:0], 3'h0, 1'b0, 1'b0, 16'h0));
      rd(`POA_A_STAT, d);
      chk(d[9:7], i[2:0]);
      c = CASES[i*12 +: 12];
      wr(`POA_A_CTRL, cf(c[6:4], c[10:8], 1'b0, 1'b0, 16'h0));
      rd(`POA_A_STAT, d);
      chk(d[9:7], c[2:0]);
    end
    wr(`POA_A_CTRL, cf(3'h7, 3'h0, 1'b0, 1'b0, 16'h0));
    rd(`POA_A_STAT, d);
    chk(d[9:7], 32'h0);
    // time channel condition at both ends of the channel range
    ld(cf(3'h0, 3'h0, 1'b0, 1'b1, 16'h0), {ps(28), 77'h0});
    chk(out_supervise, 1);
    for (i = 1; i < 64; i = i + 62) begin
      wr(`POA_A_CHAN, i);
      @(posedge sys_clk) time_chan_act <= 63'h1 << (i - 1);
      cyc(20);
      chk(req_q, 1);
      @(posedge sys_clk) time_chan_act <= ~(63'h1 << (i - 1));
      cyc(20);
      chk(req_q, 0);
    end
    // reset pulse: address match, duration, output class
    ld(cf(3'h0, 3'h1, 1'b0, 1'b0, 16'h1234), {ps(27), 77'h0});
    @(posedge sys_clk) trig_in <= {45{1'b1}};
    pulse(16'h4321);
    chk(req_q, 0);
    pulse(16'h1234);
    chk(req_q, 1);
    cyc((RP_MS - 1) * `POA_CLK_KHZ - 2000);
    chk(req_q, 1);
    cyc(`POA_CLK_KHZ + 2100);
    chk(req_q, 0);
    ld(cf(3'h0, 3'h5, 1'b0, 1'b0, 16'h1234), {ps(27), 77'h0});
    pulse(16'h1234);
    chk(req_q, 0);
    // restart window long over: normally high output idles high
    ld(cf(3'h0, 3'h0, 1'b1, 1'b1, 16'h0), {ps(40), 77'h0});
    chk(out_drive, 1);
    chk(out_supervise, 0);
    // single pulse per request rise
    ld(cf(3'h2, 3'h0, 1'b0, 1'b0, 16'h0), {ps(1), 77'h0});
    wr(`POA_A_PLEN, 32'h2);
    rd(`POA_A_PLEN, d);
    chk(d, 32'h2);
    @(posedge sys_clk) trig_in <= 45'h0;
    cyc(20);
    @(posedge sys_clk) trig_in <= 45'h1;
    cyc(5000);
    chk(out_drive, 1);
    cyc(16000);
    chk(out_drive, 0);
    chk(req_q, 1);
    // delayed activation, two ms
    ld(cf(3'h3, 3'h0, 1'b0, 1'b0, 16'h0), {ps(1), 77'h0});
    wr(`POA_A_DELAY, 32'h2);
    @(posedge sys_clk) trig_in <= 45'h0;
    cyc(20);
    @(posedge sys_clk) trig_in <= 45'h1;
    cyc(5000);
    chk(out_drive, 0);
    cyc(16000);
    chk(out_drive, 1);
    // delayed de-activation, two ms
    ld(cf(3'h6, 3'h0, 1'b0, 1'b0, 16'h0), {ps(1), 77'h0});
    wr(`POA_A_DEACT, 32'h2);
    chk(out_drive, 1);
    @(posedge sys_clk) trig_in <= 45'h0;
    cyc(5000);
    chk(req_q, 0);
    chk(out_drive, 1);
    cyc(16000);
    chk(out_drive, 0);
    final_report;
  end
endmodule // programmable_output_activation_bench
